// File: src/gcc_pkg.sv
package gcc_pkg;

   // -----------------------------------------------------------------
   // clock source selection
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      CLK_SRC_FIRST_PIN,
      CLK_SRC_SECOND_PIN,
      CLK_SRC_PTERM
   } clk_src_t;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS     = 100;
   localparam int unsigned POR_TIME_US       = 5;
   // longest time rounds down, never below one cycle
   localparam int unsigned POR_CYCLES_RAW    = (POR_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned POR_CYCLES        = (POR_CYCLES_RAW < 1) ? 1 : POR_CYCLES_RAW;
   localparam int unsigned POR_CNT_W         = 6;
   localparam logic [5:0]  POR_CNT_RST       = 6'h00;

   // -----------------------------------------------------------------
   // group layout
   // -----------------------------------------------------------------
   localparam int unsigned CELLS_PER_GROUP   = 10;
   localparam int unsigned NUM_GROUPS        = 2;
   localparam int unsigned GROUP_A           = 0;
   localparam int unsigned GROUP_B           = 1;
   localparam logic        REG_RST_VAL       = 1'b0;
   localparam logic [1:0]  SYNC_RST          = 2'h0;

   // -----------------------------------------------------------------
   // configuration of one global cell
   // -----------------------------------------------------------------
   typedef struct packed {
      clk_src_t clk_src;
      logic     io_clk_falling;
   } gcell_cfg_t;

   // -----------------------------------------------------------------
   // sum-of-products control terms into one global cell
   // -----------------------------------------------------------------
   typedef struct packed {
      logic pterm_clk;
      logic preset_sop;
      logic reset_sop;
      logic register_type_select;
   } gcell_terms_t;

   // -----------------------------------------------------------------
   // per logic control cell inputs of one group
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [CELLS_PER_GROUP-1:0] clk_falling;
      logic [CELLS_PER_GROUP-1:0] data_a;
      logic [CELLS_PER_GROUP-1:0] data_k;
      logic [CELLS_PER_GROUP-1:0] jk_mode;
   } lcc_group_t;

   function automatic logic pick_clk(input clk_src_t s, input logic p1,
                                     input logic p2, input logic pt);
      unique case (s)
         CLK_SRC_FIRST_PIN:  pick_clk = p1;
         CLK_SRC_SECOND_PIN: pick_clk = p2;
         CLK_SRC_PTERM:      pick_clk = pt;
         default:            pick_clk = p1;
      endcase
   endfunction

   // rising or falling edge of a sampled clock
   function automatic logic clk_edge(input logic cur, input logic prv,
                                     input logic falling);
      clk_edge = falling ? (prv & ~cur) : (~prv & cur);
   endfunction

endpackage

// File: src/global_cell_group.sv
`timescale 1ns/100ps
module global_cell_group (
   input  wire logic                                  i_sys_clk,
   input  wire logic                                  i_nrst,
   input  wire logic                                  i_por_done,
   input  wire logic                                  i_first_clock_pin,
   input  wire logic                                  i_second_clock_pin,
   input  wire gcc_pkg::gcell_cfg_t                   i_cfg,
   input  wire gcc_pkg::gcell_terms_t                 i_terms,
   input  wire gcc_pkg::lcc_group_t                   i_lcc,
   input  wire logic [gcc_pkg::CELLS_PER_GROUP-1:0]   i_io_data,
   output logic [gcc_pkg::CELLS_PER_GROUP-1:0]        o_lcc_q,
   output logic [gcc_pkg::CELLS_PER_GROUP-1:0]        o_io_q
);
   import gcc_pkg::*;

   // -----------------------------------------------------------------
   // clock selection and edge detect
   // -----------------------------------------------------------------
   logic sel_clk;
   logic sel_clk_ff;
   logic io_edge;
   logic [CELLS_PER_GROUP-1:0] lcc_edge;

   assign sel_clk = pick_clk(i_cfg.clk_src, i_first_clock_pin,
                             i_second_clock_pin, i_terms.pterm_clk);

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_clk_ff <= REG_RST_VAL;
      end else begin
         sel_clk_ff <= sel_clk;
      end
   end

   assign io_edge = clk_edge(sel_clk, sel_clk_ff, i_cfg.io_clk_falling);

   always_comb begin
      for (int i = 0; i < CELLS_PER_GROUP; i++) begin
         lcc_edge[i] = clk_edge(sel_clk, sel_clk_ff, i_lcc.clk_falling[i]);
      end
   end

   // -----------------------------------------------------------------
   // logic control cell registers
   // -----------------------------------------------------------------
   logic [CELLS_PER_GROUP-1:0] nxt_lcc_q;
   logic [CELLS_PER_GROUP-1:0] lcc_q_ff;

   always_comb begin
      for (int i = 0; i < CELLS_PER_GROUP; i++) begin
         nxt_lcc_q[i] = lcc_q_ff[i];
         if (lcc_edge[i]) begin
            if (i_terms.register_type_select) begin
               nxt_lcc_q[i] = i_lcc.data_a[i];
            end else if (i_lcc.jk_mode[i]) begin
               unique case ({i_lcc.data_a[i], i_lcc.data_k[i]})
                  2'b10:   nxt_lcc_q[i] = 1'b1;
                  2'b01:   nxt_lcc_q[i] = 1'b0;
                  2'b11:   nxt_lcc_q[i] = ~lcc_q_ff[i];
                  default: nxt_lcc_q[i] = lcc_q_ff[i];
               endcase
            end else begin
               nxt_lcc_q[i] = lcc_q_ff[i] ^ i_lcc.data_a[i];
            end
         end
      end
   end

   // reset wins over preset
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lcc_q_ff <= '0;
      end else if (!i_por_done || i_terms.reset_sop) begin
         lcc_q_ff <= '0;
      end else if (i_terms.preset_sop) begin
         lcc_q_ff <= '1;
      end else begin
         lcc_q_ff <= nxt_lcc_q;
      end
   end

   // -----------------------------------------------------------------
   // io cell input registers
   // -----------------------------------------------------------------
   logic [CELLS_PER_GROUP-1:0] io_q_ff;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         io_q_ff <= '0;
      end else if (!i_por_done || i_terms.reset_sop) begin
         io_q_ff <= '0;
      end else if (i_terms.preset_sop) begin
         io_q_ff <= '1;
      end else if (io_edge) begin
         io_q_ff <= i_io_data;
      end
   end

   assign o_lcc_q = lcc_q_ff;
   assign o_io_q  = io_q_ff;

endmodule

// File: src/global_clock_control_cell.sv
`timescale 1ns/100ps
module global_clock_control_cell (
   input  wire logic                                  i_sys_clk,
   input  wire logic                                  i_nrst,
   input  wire logic                                  i_first_clock_pin,
   input  wire logic                                  i_second_clock_pin,
   input  wire gcc_pkg::gcell_cfg_t                   i_cfg_a,
   input  wire gcc_pkg::gcell_cfg_t                   i_cfg_b,
   input  wire gcc_pkg::gcell_terms_t                 i_terms_a,
   input  wire gcc_pkg::gcell_terms_t                 i_terms_b,
   input  wire gcc_pkg::lcc_group_t                   i_lcc_a,
   input  wire gcc_pkg::lcc_group_t                   i_lcc_b,
   input  wire logic [gcc_pkg::CELLS_PER_GROUP-1:0]   i_io_data_a,
   input  wire logic [gcc_pkg::CELLS_PER_GROUP-1:0]   i_io_data_b,
   output logic [gcc_pkg::CELLS_PER_GROUP-1:0]        o_lcc_q_a,
   output logic [gcc_pkg::CELLS_PER_GROUP-1:0]        o_lcc_q_b,
   output logic [gcc_pkg::CELLS_PER_GROUP-1:0]        o_io_q_a,
   output logic [gcc_pkg::CELLS_PER_GROUP-1:0]        o_io_q_b,
   output logic                                       o_por_done
);
   import gcc_pkg::*;

   // -----------------------------------------------------------------
   // pin synchronisers, second and third stage must agree
   // -----------------------------------------------------------------
   logic [2:0] first_clock_pin_sync_ff;
   logic [2:0] second_clock_pin_sync_ff;
   logic       first_clock_pin_ff;
   logic       second_clock_pin_ff;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         first_clock_pin_sync_ff <= 3'h0;
         second_clock_pin_sync_ff <= 3'h0;
      end else begin
         first_clock_pin_sync_ff <= {first_clock_pin_sync_ff[1:0], i_first_clock_pin};
         second_clock_pin_sync_ff <= {second_clock_pin_sync_ff[1:0], i_second_clock_pin};
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         first_clock_pin_ff <= REG_RST_VAL;
         second_clock_pin_ff <= REG_RST_VAL;
      end else begin
         if (first_clock_pin_sync_ff[1] == first_clock_pin_sync_ff[2]) begin
            first_clock_pin_ff <= first_clock_pin_sync_ff[2];
         end
         if (second_clock_pin_sync_ff[1] == second_clock_pin_sync_ff[2]) begin
            second_clock_pin_ff <= second_clock_pin_sync_ff[2];
         end
      end
   end

   // -----------------------------------------------------------------
   // power-on clear
   // -----------------------------------------------------------------
   logic [POR_CNT_W-1:0] por_cnt_ff;
   logic                 por_done_ff;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         por_cnt_ff  <= POR_CNT_RST;
         por_done_ff <= 1'b0;
      end else if (!por_done_ff) begin
         if (por_cnt_ff == POR_CNT_W'(POR_CYCLES - 1)) begin
            por_done_ff <= 1'b1;
         end else begin
            por_cnt_ff <= por_cnt_ff + POR_CNT_W'(1);
         end
      end
   end

   assign o_por_done = por_done_ff;

   // -----------------------------------------------------------------
   // global cells A and B
   // -----------------------------------------------------------------
   global_cell_group u_group_a (
      .i_sys_clk          (i_sys_clk),
      .i_nrst             (i_nrst),
      .i_por_done         (por_done_ff),
      .i_first_clock_pin  (first_clock_pin_ff),
      .i_second_clock_pin (second_clock_pin_ff),
      .i_cfg              (i_cfg_a),
      .i_terms            (i_terms_a),
      .i_lcc              (i_lcc_a),
      .i_io_data          (i_io_data_a),
      .o_lcc_q            (o_lcc_q_a),
      .o_io_q             (o_io_q_a)
   );

   global_cell_group u_group_b (
      .i_sys_clk          (i_sys_clk),
      .i_nrst             (i_nrst),
      .i_por_done         (por_done_ff),
      .i_first_clock_pin  (first_clock_pin_ff),
      .i_second_clock_pin (second_clock_pin_ff),
      .i_cfg              (i_cfg_b),
      .i_terms            (i_terms_b),
      .i_lcc              (i_lcc_b),
      .i_io_data          (i_io_data_b),
      .o_lcc_q            (o_lcc_q_b),
      .o_io_q             (o_io_q_b)
   );

endmodule

// File: verif/gcc_checker.sv
`timescale 1ns/100ps
module gcc_checker (
   input wire logic                  i_sys_clk,
   input wire logic                  i_nrst,
   input wire gcc_pkg::gcell_cfg_t   i_cfg_a,
   input wire gcc_pkg::gcell_terms_t i_terms_a,
   input wire gcc_pkg::lcc_group_t   i_lcc_a,
   input wire logic [9:0]            i_io_data_a,
   input wire logic [9:0]            o_lcc_q_a,
   input wire logic [9:0]            o_io_q_a,
   input wire logic                  o_por_done
);
   import gcc_pkg::*;
   logic [5:0] por_cnt_ff;
   logic       run_a;
   logic       pt;
   // -----------------------------------------------------------------
   // edges since reset release, and group a running on the term clock
   // -----------------------------------------------------------------
   assign pt = i_terms_a.pterm_clk;
   assign run_a = o_por_done & (i_cfg_a.clk_src == CLK_SRC_PTERM) & ~i_terms_a.reset_sop
                  & ~i_terms_a.preset_sop;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) por_cnt_ff <= 6'h00;
      else if (por_cnt_ff != 6'h3F) por_cnt_ff <= por_cnt_ff + 6'h01;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   property p_por; o_por_done == (por_cnt_ff >= POR_CYCLES); endproperty
   a_por: assert property (p_por) else $error("power-on clear length wrong");
   property p_clear; !o_por_done |-> o_lcc_q_a == 10'h000 && o_io_q_a == 10'h000; endproperty
   a_clear: assert property (p_clear) else $error("register not clear at power-on");
   property p_rst; i_terms_a.reset_sop |=> o_lcc_q_a == 10'h000 && o_io_q_a == 10'h000; endproperty
   a_rst: assert property (p_rst) else $error("global reset missed");
   property p_pre; o_por_done && i_terms_a.preset_sop && !i_terms_a.reset_sop |=> &o_lcc_q_a; endproperty
   a_pre: assert property (p_pre) else $error("global preset missed");
   property p_tog; run_a && $rose(pt) && !i_terms_a.register_type_select && !i_lcc_a.jk_mode[0]
      && i_lcc_a.data_a[0] && !i_lcc_a.clk_falling[0] |=> o_lcc_q_a[0] != $past(o_lcc_q_a[0]); endproperty
   a_tog: assert property (p_tog) else $error("toggle missed");
   property p_load; run_a && $rose(pt) && i_terms_a.register_type_select && !i_lcc_a.clk_falling[0]
      |=> o_lcc_q_a[0] == $past(i_lcc_a.data_a[0]); endproperty
   a_load: assert property (p_load) else $error("load missed");
   property p_hold; run_a && $stable(pt) |=> $stable(o_lcc_q_a); endproperty
   a_hold: assert property (p_hold) else $error("change without clock edge");
   property p_io; run_a && i_cfg_a.io_clk_falling && $fell(pt) |=> o_io_q_a == $past(i_io_data_a); endproperty
   a_io: assert property (p_io) else $error("io falling capture missed");
   c_tog: cover property (p_tog);
   c_load: cover property (p_load);
   c_both: cover property (o_por_done && i_terms_a.preset_sop && i_terms_a.reset_sop);
endmodule
bind global_clock_control_cell gcc_checker gcc_checker_inst (.i_sys_clk, .i_nrst, .i_cfg_a,
   .i_terms_a, .i_lcc_a, .i_io_data_a, .o_lcc_q_a, .o_io_q_a, .o_por_done);

// File: verif/array_term_model.sv
`timescale 1ns/100ps
module array_term_model (
   input  wire logic i_sys_clk,
   input  wire logic i_nrst,
   input  wire logic i_en,
   input  wire logic i_slow,
   output logic      o_pterm_clk
);
   logic [1:0] div_ff;
   // term clock: every cycle or every third cycle, stands still while idle
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_ff      <= 2'h0;
         o_pterm_clk <= 1'b0;
      end else if (i_en) begin
         div_ff <= (div_ff == {i_slow, 1'b0}) ? 2'h0 : div_ff + 2'h1;
         if (div_ff == {i_slow, 1'b0}) o_pterm_clk <= ~o_pterm_clk;
      end
   end
endmodule

// File: verif/global_clock_control_cell_tb_top.sv
`timescale 1ns/100ps
module global_clock_control_cell_tb_top;
   import gcc_pkg::*;
   logic         clk, nrst, p1, p2, en, slow, ref_on, pt, pp, por_done;
   gcell_cfg_t   cfg_a, cfg_b;
   gcell_terms_t t_a, t_b;
   lcc_group_t   lcc_a, lcc_b;
   logic [2:0]   ctl_a, ctl_b;
   logic [9:0]   io_a, io_b, q_a, q_b, qi_a, qi_b, e_a, e_b, ei_a, ei_b;
   int           seed = 54124, mismatches = 0, checks_done = 0, cyc = 0, r;
   assign t_a = {pt, ctl_a};
   assign t_b = {pt, ctl_b};
   array_term_model array_term_model_inst (.i_sys_clk(clk), .i_nrst(nrst), .i_en(en),
      .i_slow(slow), .o_pterm_clk(pt));
   global_clock_control_cell global_clock_control_cell_inst (.i_sys_clk(clk), .i_nrst(nrst),
      .i_first_clock_pin(p1), .i_second_clock_pin(p2), .i_cfg_a(cfg_a), .i_cfg_b(cfg_b),
      .i_terms_a(t_a), .i_terms_b(t_b), .i_lcc_a(lcc_a), .i_lcc_b(lcc_b), .i_io_data_a(io_a),
      .i_io_data_b(io_b), .o_lcc_q_a(q_a), .o_lcc_q_b(q_b), .o_io_q_a(qi_a), .o_io_q_b(qi_b),
      .o_por_done(por_done));
   // -----------------------------------------------------------------
   // expected next state of one group
   // -----------------------------------------------------------------
   function automatic logic [9:0] nl(logic [9:0] q, lcc_group_t l, logic [2:0] c, logic pc, pv);
      logic e;
      nl = q;
      for (int i = 0; i < 10; i++) begin
         e = l.clk_falling[i] ? (pv & ~pc) : (~pv & pc);
         if (e && c[0]) nl[i] = l.data_a[i];
         else if (e && l.jk_mode[i]) nl[i] = (l.data_a[i] & ~q[i]) | (~l.data_k[i] & q[i]);
         else if (e) nl[i] = q[i] ^ l.data_a[i];
      end
      if (c[2]) nl = 10'h3FF;
      if (c[1]) nl = 10'h000;
   endfunction
   function automatic logic [9:0] ni(logic [9:0] q, d, logic f, logic [2:0] c, logic pc, pv);
      ni = (f ? (pv & ~pc) : (~pv & pc)) ? d : q;
      if (c[2]) ni = 10'h3FF;
      if (c[1]) ni = 10'h000;
   endfunction
   task automatic chk(string n, logic [9:0] e, logic [9:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic pulse(logic [1:0] w);
      {p2, p1} = w;
      repeat (6) @(posedge clk);
      #1 {p2, p1} = 2'h0;
      repeat (6) @(posedge clk);
      #1;
   endtask
   // -----------------------------------------------------------------
   // clock, timeout and cycle reference
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (++cyc == 2000) begin
      mismatches++;
      summarize();
   end
   always @(posedge clk) begin
      if (ref_on) begin
         chk("lcc a", e_a, q_a);
         chk("lcc b", e_b, q_b);
         chk("io a", ei_a, qi_a);
         chk("io b", ei_b, qi_b);
         e_a = nl(e_a, lcc_a, ctl_a, pt, pp);
         e_b = nl(e_b, lcc_b, ctl_b, pt, pp);
         ei_a = ni(ei_a, io_a, cfg_a.io_clk_falling, ctl_a, pt, pp);
         ei_b = ni(ei_b, io_b, cfg_b.io_clk_falling, ctl_b, pt, pp);
      end
      pp = pt;
   end
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      {nrst, p1, p2, en, slow, ref_on, pp} = 7'h00;
      cfg_a = '{CLK_SRC_FIRST_PIN, 1'b0};
      cfg_b = '{CLK_SRC_SECOND_PIN, 1'b1};
      {ctl_a, ctl_b} = 6'h00;
      lcc_a = '{10'h000, 10'h3FF, 10'h000, 10'h000};
      lcc_b = lcc_a;
      io_a = 10'($random(seed));
      io_b = 10'($random(seed));
      repeat (20) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (POR_CYCLES - 1) @(posedge clk);
      #1 chk("por early", 10'h000, {9'h000, por_done});
      chk("por lcc", 10'h000, q_a | q_b);
      @(posedge clk);
      #1 chk("por done", 10'h001, {9'h000, por_done});
      $display("test power-on done");
      repeat (3) pulse(2'h1);
      repeat (2) pulse(2'h2);
      chk("pin lcc a", 10'h3FF, q_a);
      chk("pin lcc b", 10'h000, q_b);
      chk("pin io a", io_a, qi_a);
      chk("pin io b", io_b, qi_b);
      $display("test pins done");
      {e_a, e_b, ei_a, ei_b} = {10'h3FF, 10'h000, io_a, io_b};
      cfg_a.clk_src = CLK_SRC_PTERM;
      cfg_b.clk_src = CLK_SRC_PTERM;
      {en, ref_on} = 2'h3;
      for (int k = 0; k < 600; k++) begin
         @(posedge clk);
         #1 r = $random(seed);
         lcc_a = 40'({$random(seed), $random(seed)});
         lcc_b = 40'({$random(seed), $random(seed)});
         ctl_a = {r[7:5] == 3'h0, r[4:2] == 3'h0, r[0]};
         ctl_b = (k == 40) ? 3'h6 : {r[15:13] == 3'h0, r[12:10] == 3'h0, r[8]};
         io_a = 10'($random(seed));
         io_b = 10'($random(seed));
         if (k == 300) begin
            {slow, cfg_a.io_clk_falling, cfg_b.io_clk_falling} = 3'h6;
         end
      end
      $display("test random done");
      summarize();
   end
endmodule
